// ### core/ppd_pkg.sv
// ppd_pkg: register map, field positions and reset values of the
// pull-up and output-mode block. assumes an 8-bit register port.
package ppd_pkg;
    localparam int unsigned PPD_AW         = 8;
    localparam int unsigned PPD_DW         = 8;
    localparam int unsigned PPD_PU_REGS    = 5;
    localparam int unsigned PPD_PORTS      = 20;
    localparam int unsigned PPD_PORT_PINS  = 8;
    localparam int unsigned PPD_GROUP_PINS = 4;
    localparam logic [7:0]  PPD_PU_BASE    = 8'h00;
    localparam logic [7:0]  PPD_OUT_MODE   = 8'h05;
    localparam logic [7:0]  PPD_STATUS     = 8'h06;
    localparam logic [7:0]  PPD_DIR_BASE   = 8'h10;
    localparam logic [7:0]  PPD_RST_VAL    = 8'h00;
    localparam logic [7:0]  PPD_OUT_MASK   = 8'h01;
    localparam int unsigned PPD_POD_BIT    = 0;
    localparam int unsigned PPD_STAT_READY = 0;
    localparam int unsigned PPD_STAT_EXT   = 1;
endpackage

// ### core/ppd_pullup_gate.sv
// ppd_pullup_gate: one group of four pins sharing a pull-up enable.
// assumes direction given is already the effective one.
`timescale 1ns/100ps
module ppd_pullup_gate
    import ppd_pkg::*;
#(
    parameter int unsigned PINS = PPD_GROUP_PINS
) (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            resetn,
    // group controls
    input  wire logic            grp_en,
    input  wire logic [PINS-1:0] dir,
    input  wire logic [PINS-1:0] port_func,
    // pads
    output logic      [PINS-1:0] pu_on
);
    wire [PINS-1:0] next_pullup;

    // direction output always wins over the group enable
    assign next_pullup = {PINS{grp_en}} & ~dir & port_func; // R2 R13

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pu_on <= '0;
        end else begin
            pu_on <= next_pullup;
        end
    end

    property p_r2;
        @(posedge clk_sys) disable iff (!resetn)
        (grp_en && !dir[0] && port_func[0]) |=> pu_on[0];
    endproperty
    a_r2: assert property (p_r2) else $error("pull-up not on for input"); // R2

    property p_r13;
        @(posedge clk_sys) disable iff (!resetn)
        (dir != '0) |=> ((pu_on & $past(dir)) == '0);
    endproperty
    a_r13: assert property (p_r13) else $error("pull-up on an output"); // R13
endmodule // ppd_pullup_gate

// ### core/ppd_port_ctrl.sv
// ppd_port_ctrl: pull-up groups, direction bits and pseudo open-drain
// select. assumes synchronous pad status inputs and an 8-bit reg port.
//
// Functional notes
// R1: one pull-up bit per four pins
// R2: pull-up needs bit one and input direction
// R3: software clears bus-control pull-ups in bus modes
// R4: bus modes still pull up port-function pins
// R5: select one turns high-side driver off; the code leaves it on while p1_data_bus is high
// R6: software keeps select zero on data bus
// R7: select still works for non-bus pin use
// R8: software avoids unsupported bit on small package
// R9: software writes ones to absent-pin locations
// R10: all inputs until mode transition completes
// R11: software refreshes unused direction registers periodically
// R12: direction one output, zero input
// R13: output direction forces pull-up off
`timescale 1ns/100ps
module ppd_port_ctrl
    import ppd_pkg::*;
#(
    parameter int unsigned NUM_PU_REGS = PPD_PU_REGS,
    parameter int unsigned NUM_PORTS   = PPD_PORTS
) (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    // register port
    input  wire logic [PPD_AW-1:0]              reg_addr,
    input  wire logic [PPD_DW-1:0]              reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [PPD_DW-1:0]              reg_rdata,
    // chip mode status
    input  wire logic                           mode_done,
    input  wire logic                           ext_bus_mode,
    input  wire logic                           p1_data_bus,
    input  wire logic [NUM_PORTS*PPD_PORT_PINS-1:0] pin_func_port,
    // pad controls
    output logic      [NUM_PORTS*PPD_PORT_PINS-1:0] pin_dir,
    output logic      [NUM_PORTS*PPD_PORT_PINS-1:0] pullup_en,
    output logic      [PPD_PORT_PINS-1:0]       high_side_off
);
    localparam int unsigned NUM_PINS   = NUM_PORTS * PPD_PORT_PINS;
    localparam int unsigned NUM_GROUPS = NUM_PU_REGS * PPD_DW;
    localparam logic [7:0]  PU_END     = 8'(NUM_PU_REGS);
    localparam logic [7:0]  DIR_END    = 8'(PPD_DIR_BASE + NUM_PORTS);

    logic [NUM_PU_REGS-1:0][PPD_DW-1:0] pu_reg;
    logic [NUM_PORTS-1:0][PPD_DW-1:0]   dir_reg;
    logic [PPD_DW-1:0]                  out_mode;
    logic                               mode_ready;

    wire [NUM_GROUPS-1:0] pu_flat;
    wire [NUM_PINS-1:0]   dir_flat;
    wire [NUM_PINS-1:0]   dir_eff;
    wire                  hit_pu;
    wire                  hit_dir;
    wire                  hit_mode;
    wire                  hit_stat;
    wire [7:0]            dir_idx;
    wire [2:0]            pu_idx;
    wire [PPD_DW-1:0]     stat_val;
    wire [PPD_DW-1:0]     next_rdata;
    wire [PPD_PORT_PINS-1:0] next_high_side_off;

    // address decode
    assign hit_pu   = (reg_addr >= PPD_PU_BASE) && (reg_addr < PU_END);
    assign hit_dir  = (reg_addr >= PPD_DIR_BASE) && (reg_addr < DIR_END);
    assign hit_mode = (reg_addr == PPD_OUT_MODE);
    assign hit_stat = (reg_addr == PPD_STATUS);
    assign dir_idx  = reg_addr - PPD_DIR_BASE;
    assign pu_idx   = reg_addr[2:0];

    assign pu_flat  = pu_reg; // R1
    assign dir_flat = dir_reg;
    // pins held as inputs until the mode change has finished
    assign dir_eff  = mode_ready ? dir_flat : '0; // R10 R12

    assign stat_val = PPD_RST_VAL
                    | (8'(mode_ready) << PPD_STAT_READY)
                    | (8'(ext_bus_mode) << PPD_STAT_EXT);

    // unmapped reads return zero
    assign next_rdata = !reg_rd   ? PPD_RST_VAL :
                        hit_pu    ? pu_reg[pu_idx] :
                        hit_dir   ? dir_reg[dir_idx] :
                        hit_mode  ? out_mode :
                        hit_stat  ? stat_val : PPD_RST_VAL;

    // data bus use overrides the select so bus drive stays push-pull
    assign next_high_side_off = {PPD_PORT_PINS{out_mode[PPD_POD_BIT]
                                              & ~p1_data_bus}}; // R5 R6 R7

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pu_reg <= '0;
        end else if (reg_wr && hit_pu) begin
            pu_reg[pu_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dir_reg <= '0;
        end else if (reg_wr && hit_dir) begin
            dir_reg[dir_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            out_mode <= PPD_RST_VAL;
        end else if (reg_wr && hit_mode) begin
            out_mode <= reg_wdata & PPD_OUT_MASK;
        end
    end

    // sticky once seen; a glitch back low must not re-float outputs
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mode_ready <= 1'b0;
        end else if (mode_done) begin
            mode_ready <= 1'b1; // R10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata     <= PPD_RST_VAL;
            pin_dir       <= '0;
            high_side_off <= '0;
        end else begin
            reg_rdata     <= next_rdata;
            pin_dir       <= dir_eff; // R12
            high_side_off <= next_high_side_off;
        end
    end

    // bus modes gate through pin_func_port only, no mode-wide block
    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
            ppd_pullup_gate #(
                .PINS (PPD_GROUP_PINS)
            ) u_gate (
                .clk_sys   (clk_sys),
                .resetn    (resetn),
                .grp_en    (pu_flat[g]), // R1 R4
                .dir       (dir_eff[g*PPD_GROUP_PINS +: PPD_GROUP_PINS]),
                .port_func (pin_func_port[g*PPD_GROUP_PINS +:
                                          PPD_GROUP_PINS]),
                .pu_on     (pullup_en[g*PPD_GROUP_PINS +: PPD_GROUP_PINS])
            );
        end
    endgenerate

    sequence s_not_ready;
        !mode_ready;
    endsequence

    sequence s_ready_dir;
        mode_ready ##1 (pin_dir == $past(dir_flat));
    endsequence

    property p_r1;
        @(posedge clk_sys) disable iff (!resetn)
        !pu_flat[0] |=> (pullup_en[3:0] == 4'h0);
    endproperty
    a_r1: assert property (p_r1) else $error("group off but pull-up on"); // R1

    property p_r10;
        @(posedge clk_sys) disable iff (!resetn)
        s_not_ready |=> (pin_dir == '0);
    endproperty
    a_r10: assert property (p_r10) else $error("output before ready"); // R10

    property p_r10_hold;
        @(posedge clk_sys) disable iff (!resetn)
        (!mode_ready && !mode_done) |=> !mode_ready;
    endproperty
    a_r10_hold: assert property (p_r10_hold) else $error("ready early"); // R10

    property p_r12;
        @(posedge clk_sys) disable iff (!resetn)
        mode_ready |-> s_ready_dir;
    endproperty
    a_r12: assert property (p_r12) else $error("direction not applied"); // R12

    property p_r5;
        @(posedge clk_sys) disable iff (!resetn)
        !out_mode[PPD_POD_BIT] |=> (high_side_off == '0);
    endproperty
    a_r5: assert property (p_r5) else $error("high side off in push-pull"); // R5

    property p_r7;
        @(posedge clk_sys) disable iff (!resetn)
        (out_mode[PPD_POD_BIT] && !p1_data_bus) |=> (&high_side_off);
    endproperty
    a_r7: assert property (p_r7) else $error("open-drain select ignored"); // R7

    property p_r4;
        @(posedge clk_sys) disable iff (!resetn)
        // pin 5: an input pin of group 1, so the bus-mode case is reachable
        (ext_bus_mode && pin_func_port[5] && pu_flat[1] && !dir_eff[5])
        |=> pullup_en[5];
    endproperty
    a_r4: assert property (p_r4) else $error("bus mode port pull-up lost"); // R4

    property p_r13;
        @(posedge clk_sys) disable iff (!resetn)
        (mode_ready && dir_flat[0]) |=> !pullup_en[0];
    endproperty
    a_r13: assert property (p_r13) else $error("output pin pulled up"); // R13
endmodule // ppd_port_ctrl

// ### bench/ppd_board.sv
// ppd_board: board side, pin use and port 1 data bus use.
// assumes the bench picks which pins leave plain port use.
`timescale 1ns/100ps
module ppd_board
    import ppd_pkg::*;
(
    // bench controls
    input  wire logic         bus_on,
    input  wire logic [159:0] not_port,
    // to block
    output logic              p1_data_bus,
    output logic      [159:0] pin_func_port
);
    // no state here; board wiring is purely static
    assign p1_data_bus   = bus_on;
    assign pin_func_port = ~not_port;
endmodule // ppd_board

// ### bench/tb_port_pullup_and_drive_mode_control.sv
// tb_port_pullup_and_drive_mode_control: register and pad tests.
// assumes the block and board model sit alone on one 50 MHz clock.
`timescale 1ns/100ps
module tb_port_pullup_and_drive_mode_control
    import ppd_pkg::*;
;
    logic         clk_sys, resetn, reg_wr, reg_rd, mode_done;
    logic         ext_bus_mode, bus_on, p1_data_bus;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, high_side_off;
    logic [159:0] not_port, pin_func_port, pin_dir, pullup_en;
    int           n_errors, checks;

    ppd_port_ctrl u_dut (.clk_sys(clk_sys), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_done(mode_done),
        .ext_bus_mode(ext_bus_mode), .p1_data_bus(p1_data_bus),
        .pin_func_port(pin_func_port), .pin_dir(pin_dir),
        .pullup_en(pullup_en), .high_side_off(high_side_off));
    ppd_board u_board (.bus_on(bus_on), .not_port(not_port),
        .p1_data_bus(p1_data_bus), .pin_func_port(pin_func_port));

    always #10 clk_sys = ~clk_sys;

    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one gap cycle after each strobe keeps every edge single-assigned
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk({152'h0, reg_rdata}, {152'h0, exp});
        @(posedge clk_sys);
    endtask

    // register write reaches pads one edge after the write edge
    task automatic pads(input logic [159:0] d, input logic [159:0] p,
                        input logic [7:0] h);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(pin_dir, d);
        chk(pullup_en, p);
        chk({152'h0, high_side_off}, {152'h0, h});
        @(posedge clk_sys);
    endtask

    task automatic stop_test();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    initial begin
        clk_sys = 1'b0;
        resetn = 1'b0;
        {reg_wr, reg_rd, mode_done, ext_bus_mode, bus_on} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        not_port = 160'h0;
        n_errors = 0;
        checks = 0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd(PPD_STATUS, 8'h00);
        rd(PPD_DIR_BASE, 8'h00);
        rd(PPD_PU_BASE, 8'h00);
        wr(PPD_DIR_BASE, 8'h0f);
        wr(PPD_PU_BASE, 8'h03);
        pads(160'h0, 160'hff, 8'h00);
        $display("test before ready done");
        mode_done <= 1'b1;
        @(posedge clk_sys);
        mode_done <= 1'b0;
        pads(160'h0f, 160'hf0, 8'h00);
        rd(PPD_STATUS, 8'h01);
        $display("test direction done");
        ext_bus_mode <= 1'b1;
        wr(PPD_PU_BASE + 8'd1, 8'h00);
        not_port <= 160'h10;
        pads(160'h0f, 160'he0, 8'h00);
        rd(PPD_STATUS, 8'h03);
        $display("test bus mode pull-up done");
        wr(PPD_OUT_MODE, 8'hff);
        rd(PPD_OUT_MODE, 8'h01);
        pads(160'h0f, 160'he0, 8'hff);
        wr(PPD_OUT_MODE, 8'h00);
        bus_on <= 1'b1;
        pads(160'h0f, 160'he0, 8'h00);
        $display("test output mode done");
        rd(8'h30, 8'h00);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        wr(PPD_DIR_BASE, 8'h0f);
        wr(PPD_PU_BASE + 8'd4, 8'h80);
        rd(PPD_DIR_BASE + 8'd19, 8'h00);
        pads(160'h0f, (160'hf << 156) | 160'he0, 8'h00);
        $display("test map edges done");
        // absent-pin port filled with ones: outputs, group pull-up dropped
        wr(PPD_DIR_BASE + 8'd19, 8'hff);
        rd(PPD_DIR_BASE + 8'd19, 8'hff);
        pads((160'hff << 152) | 160'h0f, 160'he0, 8'h00);
        $display("test absent pins done");
        stop_test();
    end
endmodule // tb_port_pullup_and_drive_mode_control
